// file: bench/crtf_cpu_model.sv
// Purpose: cpu and screen memory on the far side of the row fetch block
// Assumes: memory answers combinationally to the held screen address
// Notes: grant comes GNT_DLY + 1 cycles after request, as if an instruction ends
`timescale 1ns/1ps
`default_nettype none
module crtf_cpu_model #(
  parameter int GNT_DLY = 5 // cycles spent finishing the current instruction
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic        oe_i,
  input  wire logic [15:0] addr_i,
  output logic             grant_o,
  output logic [11:0]      data_o
);
  int          cnt_q;  // cycles since the request was seen
  logic [11:0] last_q; // last word put on the screen bus
  wire  [7:0]  row = {addr_i[11:10], 3'b000, addr_i[9:7]}; // row that formed the address
  wire  [6:0]  idx = addr_i[6:0];
  logic [11:0] word;
  // control words carry attr 5, first scan 2, last scan by row bit 0,
  // vblank and vdrive by row bit 1, double width by row bit 2
  always_comb begin
    if (idx == 7'h00) begin
      word = {4'h5, 4'h2, (row[0] ? 4'h6 : 4'hE)};
    end else if (idx == 7'h01) begin
      word = {1'b0, row[1], row[1], row[2], row};
    end else begin
      word = {4'h3, 1'b0, idx};
    end
  end
  // a released bus shows the inverse of its last value, never a held copy
  assign data_o = oe_i ? word : ~last_q;
  // grant only after the instruction ends, drop it once the request goes
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q   <= 0;
      grant_o <= 1'b0;
      last_q  <= 12'h000;
    end else begin
      // only a driven word is remembered, so a released bus holds its inverse
      if (oe_i) last_q <= word;
      if (!req_i) begin
        cnt_q   <= 0;
        grant_o <= 1'b0;
      end else if (cnt_q >= GNT_DLY) begin
        grant_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_crt_row_fetch_timing.sv
// Purpose: self-checking bench of the row fetch display timing block
// Assumes: 40 MHz clock, cpu model grants after a short delay
// Notes: each scenario is its own task and judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb_crt_row_fetch_timing;
  import crtf_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        grant;
  logic        exp_req_i = 1'b0;
  logic [11:0] scr_data;
  logic        bus_hold_request_o, line_fetch_strobe_o, scr_addr_oe_o, nmi_o;
  logic [15:0] scr_addr_o;
  logic [7:0]  chargen_code_o, row_num_o, disp_code_o;
  logic [3:0]  attr_latch_o, line_attr_o, scan_num_o, disp_attr_o;
  crtf_video_t video_o;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] rd;

  always #12.5 sys_clk_i = ~sys_clk_i;

  crtf_row_fetch uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_hold_grant_i(grant), .exp_req_i(exp_req_i), .scr_data_i(scr_data),
    .bus_hold_request_o(bus_hold_request_o), .line_fetch_strobe_o(line_fetch_strobe_o),
    .scr_addr_o(scr_addr_o), .scr_addr_oe_o(scr_addr_oe_o), .chargen_code_o(chargen_code_o),
    .attr_latch_o(attr_latch_o), .disp_code_o(disp_code_o), .disp_attr_o(disp_attr_o),
    .line_attr_o(line_attr_o),
    .row_num_o(row_num_o), .scan_num_o(scan_num_o), .video_o(video_o), .nmi_o(nmi_o));

  crtf_cpu_model cpu (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(bus_hold_request_o),
    .oe_i(scr_addr_oe_o), .addr_i(scr_addr_o), .grant_o(grant), .data_o(scr_data));

  // compare and count, report at once on a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_i);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    // waitrequest is sampled on the rising edge; only the cycle limit ends a hang
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk(k, 2);
  endtask

  // registers read back zero after reset, unmapped place ignores writes
  task automatic t_reset;
    chk({bus_hold_request_o, line_fetch_strobe_o, nmi_o}, 0);
    chk(scr_addr_o, 32'h8000);
    for (int a = 0; a < 16; a += 4) begin
      av(1'b0, a[3:0], 0);
      chk(rd, 0);
    end
    av(1'b1, 4'hC, 32'hFFFF_FFFF);
    av(1'b0, 4'hC, 0);
    chk(rd, 0);
  endtask

  // expansion request reaches the cpu through the same request line
  task automatic t_exp;
    @(posedge sys_clk_i);
    exp_req_i <= 1'b1;
    repeat (5) @(negedge sys_clk_i);
    chk(bus_hold_request_o, 1);
    @(posedge sys_clk_i);
    exp_req_i <= 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk(bus_hold_request_o, 0);
  endtask

  // one blanking pulse per scan line of H_TOTAL slots
  task automatic t_blank;
    int n, nh;
    logic p;
    n = 0;
    nh = 0;
    p = video_o.hblank;
    repeat (1000) begin
      @(negedge sys_clk_i);
      if (video_o.hblank === 1'b1 && p === 1'b0) n++;
      if (video_o.hdrive === 1'b1) nh++;
      p = video_o.hblank;
    end
    chk(n, 10);
    chk(nh, 80);
  endtask

  // fetch one row and follow it through its scans to the release of the bus
  task automatic t_row(input logic [7:0] row, input logic [31:0] ctrl,
                       input logic [3:0] lastv, input int nmis);
    int k, n, nd, bp;
    logic [3:0] mx;
    av(1'b1, 4'h8, {24'h0, row});
    av(1'b1, 4'h0, ctrl);
    k = 0;
    while (bus_hold_request_o !== 1'b1 && k < 20) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk(bus_hold_request_o, 1);
    chk(line_fetch_strobe_o, 0);
    while (line_fetch_strobe_o !== 1'b1 && k < 60) begin
      @(negedge sys_clk_i);
      k++;
    end
    // the first address stands one edge after the strobe rises
    @(negedge sys_clk_i);
    // control words, then 80 characters, row bits compressed into the address
    for (int i = 0; i < 82; i++) begin
      chk({scr_addr_oe_o, scr_addr_o}, {1'b1, 4'h8, row[7:6], row[2:0], i[6:0]});
      @(negedge sys_clk_i);
    end
    n = 0;
    nd = 0;
    bp = 0;
    mx = 4'h0;
    k = 0;
    while (bus_hold_request_o === 1'b1 && k < 3000) begin
      if (nmi_o === 1'b1) n++;
      if (row_num_o === row && scan_num_o > mx) mx = scan_num_o;
      // once this row is loaded each displayed line runs codes 2 upward
      if (row_num_o === row && video_o.den === 1'b1) begin
        chk({disp_attr_o, disp_code_o}, {4'h3, 8'h02 + 8'(row[2] ? bp / 2 : bp)});
        bp++;
        nd++;
      end else begin
        bp = 0;
      end
      @(negedge sys_clk_i);
      k++;
    end
    chk(line_fetch_strobe_o, 0);
    chk(mx, lastv);
    chk(row_num_o, row);
    chk(line_attr_o, 4'h5);
    chk({attr_latch_o, chargen_code_o}, 12'h351);
    repeat (300) begin
      if (nmi_o === 1'b1) n++;
      chk(bus_hold_request_o, 0);
      @(negedge sys_clk_i);
    end
    chk(n, nmis);
    chk(video_o.vblank, row[1]);
    chk(video_o.vdrive, row[1]);
    chk(nd > 0, !row[1]);
  endtask

  // closing report, reached from the main sequence or the cycle limit
  task automatic test_done;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // cycle ceiling well above the expected run length
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_exp();
    t_blank();
    t_row(8'hC5, 32'h2, 4'h6, 0);
    t_row(8'h42, 32'h6, 4'h9, 1);
    t_row(8'h01, 32'h2, 4'h6, 0);
    test_done();
  end
endmodule
`default_nettype wire

// file: core/crtf_pkg.sv
// Purpose: types of the row fetch display timing block
// Assumes: constants come from crtf_regs.svh
// Notes: none
`include "crtf_regs.svh"
package crtf_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_FETCH, ST_ALIGN, ST_DISP} crtf_state_t;
  typedef enum logic [1:0] {CH_ACT, CH_BLANK, CH_LINK} crtf_chst_t;
  // fetch tag travelling beside the synchronised screen data
  typedef struct packed {
    logic       v;
    logic [6:0] idx;
  } crtf_tag_t;
  // monitor timing outputs
  typedef struct packed {
    logic hblank;
    logic hdrive;
    logic vblank;
    logic vdrive;
    logic den;
  } crtf_video_t;
endpackage

// file: core/crtf_regs.svh
// Purpose: constants of the row fetch display timing block
// Assumes: included by crtf_pkg and by crtf_row_fetch
// Notes: register offsets are byte addresses on the Avalon-MM slave
`ifndef CRTF_REGS_SVH
`define CRTF_REGS_SVH
`define CRTF_OFF_CTRL   4'h0
`define CRTF_OFF_STAT   4'h4
`define CRTF_OFF_START  4'h8
`define CRTF_CTRL_AUTO  0
`define CRTF_CTRL_GO    1
`define CRTF_CTRL_NMI   2
`define CRTF_CTRL_RST   3'h0
`define CRTF_START_RST  8'h00
`define CRTF_SCANS      4'hA
`define CRTF_HDR_WORDS  7'h02
`define CRTF_CHARS      7'h50
`define CRTF_LAST_IDX   7'h51
`define CRTF_SCR_BASE   16'h8000
`define CRTF_W0_LAST    0
`define CRTF_W0_FIRST   4
`define CRTF_W0_ATTR    8
`define CRTF_W1_LINK    0
`define CRTF_W1_DW      8
`define CRTF_W1_VDRV    9
`define CRTF_W1_VBLK    10
`define CRTF_ST_ROW     0
`define CRTF_ST_SCAN    8
`define CRTF_ST_LAST    12
`define CRTF_ST_REQ     16
`define CRTF_ST_GNT     17
`define CRTF_ST_STB     18
`define CRTF_ST_ATTR    19
`endif

// file: core/crtf_row_fetch.sv
// Purpose: row fetch and display timing of a text terminal controller
// Assumes: one 40 MHz clock, one character slot per clock
// Notes: screen memory answers combinationally to the held address
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "crtf_regs.svh"
module crtf_row_fetch
  import crtf_pkg::*;
#(
  parameter int unsigned H_TOTAL = 100, // slots per scan line
  parameter int unsigned H_LINK  = 8,   // link slots at end of line
  parameter int unsigned HS_BEG  = 84,  // drive pulse start slot
  parameter int unsigned HS_END  = 92   // drive pulse end slot
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        bus_hold_grant_i,
  input  wire logic        exp_req_i,
  input  wire logic [11:0] scr_data_i,
  output logic             bus_hold_request_o,
  output logic             line_fetch_strobe_o,
  output logic [15:0]      scr_addr_o,
  output logic             scr_addr_oe_o,
  output logic [7:0]       chargen_code_o,
  output logic [3:0]       attr_latch_o,
  output logic [7:0]       disp_code_o,
  output logic [3:0]       disp_attr_o,
  output logic [3:0]       line_attr_o,
  output logic [7:0]       row_num_o,
  output logic [3:0]       scan_num_o,
  output crtf_video_t      video_o,
  output logic             nmi_o
);

  // screen address: page pair from row top bits, row slot, position
  function automatic logic [11:0] fetch_addr(input logic [7:0] row,
                                             input logic [6:0] idx);
    fetch_addr = {row[7:6], row[2:0], idx};
  endfunction

  crtf_state_t st_q;            // row fetch state
  crtf_chst_t  ch_q;            // character counter state
  logic [7:0]  pos_q;           // character position in the scan
  logic        hb1_q;           // blanking timing latch
  logic        hb2_q;           // second stage for edge find
  logic        gnt_m_q;         // grant synchroniser
  logic        gnt_s_q;
  logic        exp_m_q;         // expansion request synchroniser
  logic        exp_s_q;
  logic [11:0] dat_m_q;         // screen data synchroniser
  logic [11:0] dat_s_q;
  crtf_tag_t   tag_q [3];       // tags matching the data pipeline
  logic [6:0]  rd_idx_q;        // next word to address
  logic [11:0] w0_q;            // staged control word 0
  logic [11:0] w1_q;            // staged control word 1
  logic [11:0] lbuf [80];       // line buffer
  logic [7:0]  fetch_row_q;     // row being fetched
  logic [7:0]  next_row_q;      // link to following row
  logic [7:0]  row_q;           // displayed row number
  logic [3:0]  scan_q;          // scan counter
  logic [3:0]  last_q;          // last scan number
  logic [3:0]  lattr_q;         // whole row attributes
  logic        dw_q;            // double width
  logic        vdrv_q;          // vertical drive
  logic        vblk_q;          // vertical blanking
  logic        vblk_d_q;        // previous vblank for nmi edge
  logic        ctrl_req_q;      // controller hold request
  logic        stb_q;           // line fetch strobe
  logic [2:0]  ctrl_q;          // auto, go, nmi enable
  logic        go_q;            // pending single row command
  logic [7:0]  start_q;         // start row after idle
  logic        ack_q;           // bus answer phase
  logic [31:0] rdat_q;          // read data

  // decode of timing and bus
  wire tick      = hb1_q & ~hb2_q; // delayed blanking edge
  wire hblank    = (ch_q != CH_ACT);
  wire row_done  = (scan_q == last_q) || (scan_q == `CRTF_SCANS - 4'h1);
  wire pipe_busy = tag_q[0].v | tag_q[1].v | tag_q[2].v;
  wire issue_end = (st_q == ST_FETCH) && (rd_idx_q == `CRTF_LAST_IDX);
  wire start_cmd = ctrl_q[`CRTF_CTRL_AUTO] | go_q;
  wire acc       = avs_read | avs_write;
  wire wr_do     = avs_write & ack_q;
  wire [6:0] ridx = dw_q ? {1'b0, pos_q[6:1]} : pos_q[6:0];
  wire disp_act  = (ch_q == CH_ACT) && !vblk_q;
  wire [7:0] ht_last  = 8'(H_TOTAL - 1);
  wire [7:0] lnk_from = 8'(H_TOTAL - H_LINK - 1);
  wire in_hs = (pos_q >= 8'(HS_BEG)) && (pos_q < 8'(HS_END));

  // expansion request merged without passing the controller logic
  assign bus_hold_request_o  = ctrl_req_q | exp_s_q;
  assign line_fetch_strobe_o = stb_q;
  assign scr_addr_oe_o       = stb_q;
  assign avs_waitrequest     = acc & ~ack_q;
  assign avs_readdata        = rdat_q;

  // pin synchronisers; first stages feed only second stages
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gnt_m_q <= 1'b0;
      gnt_s_q <= 1'b0;
      exp_m_q <= 1'b0;
      exp_s_q <= 1'b0;
      dat_m_q <= 12'h000;
      dat_s_q <= 12'h000;
    end else begin
      gnt_m_q <= bus_hold_grant_i;
      gnt_s_q <= gnt_m_q;
      exp_m_q <= exp_req_i;
      exp_s_q <= exp_m_q;
      dat_m_q <= scr_data_i;
      dat_s_q <= dat_m_q;
    end
  end

  // character counter state machine over one scan line
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_q <= 8'h00;
      ch_q  <= CH_ACT;
    end else begin
      pos_q <= (pos_q == ht_last) ? 8'h00 : pos_q + 8'h01;
      unique case (ch_q)
        CH_ACT: begin
          if (pos_q == 8'(`CRTF_CHARS) - 8'h01) ch_q <= CH_BLANK;
        end
        CH_BLANK: begin
          if (pos_q == lnk_from) ch_q <= CH_LINK;
        end
        CH_LINK: begin
          if (pos_q == ht_last) ch_q <= CH_ACT;
        end
      endcase
    end
  end

  // blanking timing latch; its rising edge clocks row loads
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hb1_q <= 1'b0;
      hb2_q <= 1'b0;
    end else begin
      hb1_q <= hblank;
      hb2_q <= hb1_q;
    end
  end

  // row fetch sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= ST_IDLE;
      ctrl_req_q  <= 1'b0;
      stb_q       <= 1'b0;
      rd_idx_q    <= 7'h00;
      fetch_row_q <= 8'h00;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          // stays here until software or auto mode asks
          if (start_cmd) begin
            st_q        <= ST_REQ;
            ctrl_req_q  <= 1'b1;
            fetch_row_q <= go_q ? start_q : next_row_q;
          end
        end
        ST_REQ: begin
          // cpu finishes its instruction before granting
          if (gnt_s_q) begin
            st_q     <= ST_FETCH;
            stb_q    <= 1'b1;
            rd_idx_q <= 7'h00;
          end
        end
        ST_FETCH: begin
          // two control words then the characters of the row
          if (issue_end) st_q <= ST_ALIGN;
          else rd_idx_q <= rd_idx_q + 7'h01;
        end
        ST_ALIGN: begin
          if (tick && !pipe_busy) st_q <= ST_DISP;
        end
        ST_DISP: begin
          if (tick && row_done) begin
            st_q       <= ST_IDLE;
            ctrl_req_q <= 1'b0;
            stb_q      <= 1'b0;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // screen address: character range only, attribute chips follow
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scr_addr_o <= `CRTF_SCR_BASE;
    end else if (st_q == ST_FETCH) begin
      scr_addr_o <= `CRTF_SCR_BASE | {4'h0, fetch_addr(fetch_row_q, rd_idx_q)};
    end
  end

  // tag pipeline; matches the screen address register plus the two stage data synchroniser
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) tag_q[i] <= '0;
    end else begin
      tag_q[0] <= '{v: (st_q == ST_FETCH), idx: rd_idx_q};
      tag_q[1] <= tag_q[0];
      tag_q[2] <= tag_q[1];
    end
  end

  // capture of each 12-bit word; chargen and attribute see the character words only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w0_q           <= 12'h000;
      w1_q           <= 12'h000;
      chargen_code_o <= 8'h00;
      attr_latch_o   <= 4'h0;
    end else if (tag_q[2].v) begin
      if (tag_q[2].idx == 7'h00) w0_q <= dat_s_q;
      else if (tag_q[2].idx == 7'h01) w1_q <= dat_s_q;
      else begin
        chargen_code_o <= dat_s_q[7:0];
        attr_latch_o   <= dat_s_q[11:8];
      end
    end
  end

  // line buffer write; no reset since contents are always refetched
  always_ff @(posedge sys_clk_i) begin
    if (tag_q[2].v && tag_q[2].idx >= `CRTF_HDR_WORDS) begin
      lbuf[tag_q[2].idx - `CRTF_HDR_WORDS] <= dat_s_q;
    end
  end

  // row registers load together on the delayed blanking edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_q      <= 8'h00;
      next_row_q <= 8'h00;
      scan_q     <= 4'h0;
      last_q     <= 4'h0;
      lattr_q    <= 4'h0;
      dw_q       <= 1'b0;
      vdrv_q     <= 1'b0;
      vblk_q     <= 1'b0;
    end else if (st_q == ST_ALIGN && tick && !pipe_busy) begin
      row_q      <= fetch_row_q;
      next_row_q <= w1_q[`CRTF_W1_LINK +: 8];
      scan_q     <= w0_q[`CRTF_W0_FIRST +: 4];
      last_q     <= w0_q[`CRTF_W0_LAST +: 4];
      lattr_q    <= w0_q[`CRTF_W0_ATTR +: 4];
      dw_q       <= w1_q[`CRTF_W1_DW];
      vdrv_q     <= w1_q[`CRTF_W1_VDRV];
      vblk_q     <= w1_q[`CRTF_W1_VBLK];
    end else if (st_q == ST_DISP && tick && !row_done) begin
      scan_q <= scan_q + 4'h1;
    end
  end

  // display path and monitor drive
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_code_o <= 8'h00;
      disp_attr_o <= 4'h0;
      video_o     <= '0;
    end else begin
      if (disp_act) begin
        disp_code_o <= lbuf[ridx][7:0];
        disp_attr_o <= lbuf[ridx][11:8];
      end
      video_o.hblank <= hblank;
      video_o.hdrive <= hblank & in_hs;
      video_o.vblank <= vblk_q;
      video_o.vdrive <= vdrv_q;
      video_o.den    <= disp_act & ~(dw_q & pos_q[7]);
    end
  end

  assign line_attr_o = lattr_q;
  assign row_num_o   = row_q;
  assign scan_num_o  = scan_q;

  // one nmi pulse at the start of each vertical retrace
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vblk_d_q <= 1'b0;
      nmi_o    <= 1'b0;
    end else begin
      vblk_d_q <= vblk_q;
      nmi_o    <= vblk_q & ~vblk_d_q & ctrl_q[`CRTF_CTRL_NMI];
    end
  end

  // avalon slave: one wait cycle, writes land at the answer edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
      ctrl_q  <= `CRTF_CTRL_RST;
      start_q <= `CRTF_START_RST;
      go_q    <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          `CRTF_OFF_CTRL:  rdat_q <= {29'h0, ctrl_q};
          `CRTF_OFF_START: rdat_q <= {24'h0, start_q};
          `CRTF_OFF_STAT:  rdat_q <= {9'h0, lattr_q, stb_q, gnt_s_q,
                                      ctrl_req_q, last_q, scan_q, row_q};
          default:         rdat_q <= 32'h0000_0000;
        endcase
      end
      // a taken command clears go, a new write sets it again
      if (st_q == ST_IDLE && start_cmd) go_q <= 1'b0;
      if (wr_do && avs_byteenable[0]) begin
        if (avs_address == `CRTF_OFF_CTRL) begin
          ctrl_q <= avs_writedata[2:0];
          if (avs_writedata[`CRTF_CTRL_GO]) go_q <= 1'b1;
        end
        if (avs_address == `CRTF_OFF_START) start_q <= avs_writedata[7:0];
      end
    end
  end

  // helper for the word count check: cycles spent in the fetch state,
  // counted apart from the read index so a broken index still trips it
  logic [6:0] fetch_cyc_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_cyc_q <= 7'h00;
    end else begin
      fetch_cyc_q <= (st_q == ST_FETCH) ? fetch_cyc_q + 7'h01 : 7'h00;
    end
  end

  // checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_granted;
    (st_q == ST_REQ) ##1 (st_q == ST_FETCH);
  endsequence
  sequence s_word_done;
    issue_end ##1 (st_q == ST_ALIGN);
  endsequence

  exp_merge_a: assert property ((exp_req_i)[*3] |=> bus_hold_request_o)
    else $error("expansion request not passed to bus hold");
  grant_fetch_a: assert property (s_granted |-> $past(gnt_s_q) && stb_q)
    else $error("fetch began without grant");
  word_count_a: assert property (s_word_done |-> $past(fetch_cyc_q) == 7'h51)
    else $error("row fetch word count wrong");
  scan_step_a: assert property ((st_q == ST_DISP && tick && !row_done)
                                |=> scan_q == $past(scan_q) + 4'h1)
    else $error("scan counter did not step");
  row_release_a: assert property ((st_q == ST_DISP && tick && row_done)
                                  |=> !ctrl_req_q && !stb_q && st_q == ST_IDLE)
    else $error("bus not released after last scan");
  ten_scans_a: assert property (st_q == ST_DISP |-> scan_q < `CRTF_SCANS)
    else $error("scan count past ten");
  blank_end_a: assert property ((ch_q == CH_ACT && pos_q == 8'h4F)
                                |-> ##2 video_o.hblank)
    else $error("no blanking after displayed characters");
  nmi_once_a: assert property (nmi_o |-> vblk_d_q ##1 !nmi_o)
    else $error("nmi not a single pulse in retrace");
  row_load_a: assert property ((st_q == ST_ALIGN && tick && !pipe_busy)
                               |=> row_q == $past(fetch_row_q) && st_q == ST_DISP)
    else $error("row registers not loaded on blanking edge");
  chargen_a: assert property ((tag_q[2].v && tag_q[2].idx > 7'h01)
                              |=> chargen_code_o == $past(dat_s_q[7:0]))
    else $error("character not sent to generator");
  req_first_a: assert property ($rose(stb_q) |-> ctrl_req_q)
    else $error("strobe without hold request");

endmodule
`default_nettype wire
